// File: tb/asrw_tx_model.sv
`timescale 1ns/100ps
module asrw_tx_model
(
   // Clock
   input wire logic clk_i,
   // Serial line towards the receiver
   output logic line_o
);
   // Polarity seen by the receiver; the idle level is its inverse
   logic inv = 1'b0;

   initial line_o = 1'b1;

   // Polarity change; the caller keeps reception off meanwhile
   task automatic set_inv(input logic v);
      @(posedge clk_i);
      inv = v;
      line_o <= ~v;
   endtask

   // One frame: start, n data bits, stop; per sets slow or quick bits
   task automatic send(input logic [8:0] d, input int n, input int per,
                       input logic stop);
      @(posedge clk_i);
      line_o <= inv;
      repeat (per) @(posedge clk_i);
      for (int i = 0; i < n; i++)
      begin
         line_o <= d[i] ^ inv;
         repeat (per) @(posedge clk_i);
      end
      line_o <= stop ^ inv;
      repeat (per) @(posedge clk_i);
      line_o <= ~inv;
   endtask

   // All-zero break; no early rising edge, then the line returns to idle
   task automatic brk(input int nclk);
      @(posedge clk_i);
      line_o <= inv;
      repeat (nclk) @(posedge clk_i);
      line_o <= ~inv;
   endtask
endmodule // asrw_tx_model

// File: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   // Design-facing signals
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic sleep = 1'b0;
   logic line;
   logic irq_high;
   logic irq_low;
   logic [7:0] rd_data;
   asrw_pkg::asrw_req_t bus = '0;
   int error_cnt = 0;
   int total_checks = 0;
   int per = 16;
   // Baud settings: sync/speed, baud control, divisor high, divisor low
   logic [7:0] cfg [3][4] = '{'{8'h00, 8'h00, 8'h00, 8'h00},
      '{8'h00, 8'h08, 8'h00, 8'h01}, '{8'h04, 8'h00, 8'h00, 8'h00}};
   int cfg_per [3] = '{64, 32, 16};

   always #5 ref_clk = ~ref_clk;

   asrw_rx i_asrw_rx (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .bus_i(bus),
      .rd_data_o(rd_data), .rx_line_i(line), .sleep_i(sleep),
      .irq_high_o(irq_high), .irq_low_o(irq_low));
   asrw_tx_model i_asrw_tx_model (.clk_i(ref_clk), .line_o(line));

   // Compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      if (error_cnt == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      bus.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e,
                         input logic [7:0] m = 8'hFF);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      bus.rd <= 1'b0;
      #1;
      chk(rd_data & m, e);
   endtask

   // Frame at the current bit length, then let the flags settle
   task automatic frame(input logic [8:0] d, input int n = 8,
                        input logic stop = 1'b1);
      i_asrw_tx_model.send(d, n, per, stop);
      cyc(2);
   endtask

   // Hang guard
   initial
   begin
      repeat (100000) @(posedge ref_clk);
      error_cnt++;
      $display("[ERR] %0t ns: run timed out", $time);
      close_out();
   end

   // Main sequence
   initial
   begin
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd_chk(asrw_pkg::ADDR_STATUS, 8'h00);
      rd_chk(asrw_pkg::ADDR_BAUD_CTRL, 8'h00, 8'hBF);
      rd_chk(asrw_pkg::ADDR_IRQ_FLAGS, 8'h00);
      wr(asrw_pkg::ADDR_BAUD_CTRL, 8'h3C);
      rd_chk(asrw_pkg::ADDR_BAUD_CTRL, 8'h38, 8'hBF);
      rd_chk(4'hF, 8'h00);
      wr(asrw_pkg::ADDR_IRQ_ENABLES, 8'h20);
      // Every baud setting carries one frame; last one stays
      for (int i = 0; i < 3; i++)
      begin
         wr(asrw_pkg::ADDR_STATUS, 8'h80);
         wr(asrw_pkg::ADDR_TX_STATUS, cfg[i][0]);
         wr(asrw_pkg::ADDR_BAUD_CTRL, cfg[i][1]);
         wr(asrw_pkg::ADDR_DIV_HIGH, cfg[i][2]);
         wr(asrw_pkg::ADDR_DIV_LOW, cfg[i][3]);
         wr(asrw_pkg::ADDR_STATUS, 8'h90);
         per = cfg_per[i];
         frame({1'b0, 8'h4D + 8'(i)});
         chk({6'h00, irq_high, irq_low}, 8'h01);
         rd_chk(asrw_pkg::ADDR_IRQ_FLAGS, 8'h20);
         rd_chk(asrw_pkg::ADDR_STATUS, 8'h90);
         rd_chk(asrw_pkg::ADDR_RX_BUFFER, 8'h4D + 8'(i));
         cyc(3);
         chk({6'h00, irq_high, irq_low}, 8'h00);
      end
      chk(rd_data, 8'h00);
      // Priority steers the request to the high line
      wr(asrw_pkg::ADDR_IRQ_PRIO, 8'h20);
      frame(9'h05A);
      chk({6'h00, irq_high, irq_low}, 8'h02);
      rd_chk(asrw_pkg::ADDR_RX_BUFFER, 8'h5A);
      wr(asrw_pkg::ADDR_IRQ_PRIO, 8'h00);
      // Flag without request when the enable is clear
      wr(asrw_pkg::ADDR_IRQ_ENABLES, 8'h00);
      frame(9'h0E1);
      chk({6'h00, irq_high, irq_low}, 8'h00);
      rd_chk(asrw_pkg::ADDR_IRQ_FLAGS, 8'h20);
      rd_chk(asrw_pkg::ADDR_RX_BUFFER, 8'hE1);
      wr(asrw_pkg::ADDR_IRQ_ENABLES, 8'h20);
      // Third unread frame overruns; later frames are refused
      frame(9'h011);
      frame(9'h022);
      frame(9'h033);
      rd_chk(asrw_pkg::ADDR_STATUS, 8'h92);
      rd_chk(asrw_pkg::ADDR_RX_BUFFER, 8'h11);
      rd_chk(asrw_pkg::ADDR_RX_BUFFER, 8'h22);
      frame(9'h044);
      rd_chk(asrw_pkg::ADDR_IRQ_FLAGS, 8'h00);
      wr(asrw_pkg::ADDR_STATUS, 8'h80);
      rd_chk(asrw_pkg::ADDR_STATUS, 8'h80);
      wr(asrw_pkg::ADDR_STATUS, 8'h90);
      // Low stop bit
      frame(9'h0C3, 8, 1'b0);
      rd_chk(asrw_pkg::ADDR_STATUS, 8'h94);
      rd_chk(asrw_pkg::ADDR_RX_BUFFER, 8'hC3);
      // Nine bits, then address filtering
      wr(asrw_pkg::ADDR_STATUS, 8'hD0);
      frame(9'h13C, 9);
      rd_chk(asrw_pkg::ADDR_STATUS, 8'hD1);
      rd_chk(asrw_pkg::ADDR_RX_BUFFER, 8'h3C);
      wr(asrw_pkg::ADDR_STATUS, 8'hD8);
      frame(9'h077, 9);
      rd_chk(asrw_pkg::ADDR_IRQ_FLAGS, 8'h00);
      frame(9'h155, 9);
      rd_chk(asrw_pkg::ADDR_STATUS, 8'hD9);
      rd_chk(asrw_pkg::ADDR_RX_BUFFER, 8'h55);
      wr(asrw_pkg::ADDR_STATUS, 8'hD0);
      frame(9'h066, 9);
      rd_chk(asrw_pkg::ADDR_RX_BUFFER, 8'h66);
      // Inverted line; reception is off while polarity changes
      wr(asrw_pkg::ADDR_STATUS, 8'h80);
      i_asrw_tx_model.set_inv(1'b1);
      wr(asrw_pkg::ADDR_BAUD_CTRL, 8'h20);
      wr(asrw_pkg::ADDR_STATUS, 8'h90);
      frame(9'h096);
      rd_chk(asrw_pkg::ADDR_RX_BUFFER, 8'h96);
      wr(asrw_pkg::ADDR_STATUS, 8'h80);
      i_asrw_tx_model.set_inv(1'b0);
      wr(asrw_pkg::ADDR_BAUD_CTRL, 8'h00);
      // No frame while continuous receive, port or async mode is off
      frame(9'h0A1);
      rd_chk(asrw_pkg::ADDR_IRQ_FLAGS, 8'h00);
      wr(asrw_pkg::ADDR_STATUS, 8'h10);
      frame(9'h0A2);
      rd_chk(asrw_pkg::ADDR_IRQ_FLAGS, 8'h00);
      wr(asrw_pkg::ADDR_TX_STATUS, 8'h14);
      wr(asrw_pkg::ADDR_STATUS, 8'h90);
      frame(9'h0A3);
      rd_chk(asrw_pkg::ADDR_IRQ_FLAGS, 8'h00);
      wr(asrw_pkg::ADDR_TX_STATUS, 8'h04);
      // Sleep stops the baud generator
      @(posedge ref_clk);
      sleep <= 1'b1;
      frame(9'h0A4);
      rd_chk(asrw_pkg::ADDR_IRQ_FLAGS, 8'h00);
      // Wake on a break while asleep, then normal reception again
      rd_chk(asrw_pkg::ADDR_BAUD_CTRL, 8'h40, 8'h40);
      wr(asrw_pkg::ADDR_BAUD_CTRL, 8'h02);
      fork
         i_asrw_tx_model.brk(12 * per);
         begin
            cyc(40);
            rd_chk(asrw_pkg::ADDR_IRQ_FLAGS, 8'h20);
            rd_chk(asrw_pkg::ADDR_BAUD_CTRL, 8'h02, 8'h02);
         end
      join
      cyc(3);
      rd_chk(asrw_pkg::ADDR_BAUD_CTRL, 8'h00, 8'h02);
      rd_chk(asrw_pkg::ADDR_RX_BUFFER, 8'h00, 8'h00);
      rd_chk(asrw_pkg::ADDR_IRQ_FLAGS, 8'h00);
      @(posedge ref_clk);
      sleep <= 1'b0;
      frame(9'h03A);
      rd_chk(asrw_pkg::ADDR_RX_BUFFER, 8'h3A);
      close_out();
   end
endmodule // tb_top

// File: verilog/asrw_pkg.sv
package asrw_pkg;

   // Register indices on the plain register port
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_BAUD_CTRL = 4'h1;
   localparam logic [3:0] ADDR_DIV_HIGH = 4'h2;
   localparam logic [3:0] ADDR_DIV_LOW = 4'h3;
   localparam logic [3:0] ADDR_RX_BUFFER = 4'h4;
   localparam logic [3:0] ADDR_IRQ_FLAGS = 4'h5;
   localparam logic [3:0] ADDR_IRQ_ENABLES = 4'h6;
   localparam logic [3:0] ADDR_IRQ_PRIO = 4'h7;
   localparam logic [3:0] ADDR_TX_STATUS = 4'h8;

   // Receive status and control bit positions
   localparam int STS_PORT_EN = 7;
   localparam int STS_NINE_BIT = 6;
   localparam int STS_CONT_RX = 4;
   localparam int STS_ADDR_DET = 3;
   localparam int STS_FRAME_ERR = 2;
   localparam int STS_OVERRUN = 1;
   localparam int STS_NINTH = 0;

   // Baud control bit positions
   localparam int BC_RX_IDLE = 6;
   localparam int BC_RX_POL = 5;
   localparam int BC_TX_POL = 4;
   localparam int BC_WIDE_DIV = 3;
   localparam int BC_WAKE = 1;

   // Transmit status and control bits used here
   localparam int TS_SYNC = 4;
   localparam int TS_HIGH_SPEED = 2;

   // Receive flag, enable and priority sit at the same bit
   localparam int IRQ_RX_BIT = 5;

   // Oversampling, frame length and buffer depth counts
   localparam logic [3:0] SMP_START_MID = 4'h7;
   localparam logic [3:0] SMP_LAST = 4'hF;
   localparam logic [1:0] PRE_X64_LAST = 2'h3;
   localparam logic [3:0] BITS_EIGHT = 4'h8;
   localparam logic [3:0] BITS_NINE = 4'h9;
   localparam logic [1:0] FIFO_DEPTH = 2'h2;

   // Register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } asrw_req_t;

   // Receiver sequencer
   typedef enum logic [3:0] {
      RX_IDLE = 4'h1,
      RX_START = 4'h2,
      RX_DATA = 4'h4,
      RX_STOP = 4'h8
   } asrw_fsm_t;

   // One buffer entry: framing error, ninth bit, data
   typedef struct packed {
      logic framing_error_flag;
      logic ninth;
      logic [7:0] data;
   } asrw_entry_t;

endpackage

// File: verilog/asrw_rx.sv
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/100ps
// Notes on behaviour
// - Line sampled sixteen times per bit; shifter advances once per bit.
// - Polarity bit set inverts the receive line before recovery.
// - Async needs sync-select clear and port enable set.
// - Divisor bytes plus speed and wide selects give the baud rate.
// - Nine-bit enable receives nine bits; ninth shows in status.
// - Frames are received only while continuous receive is set.
// - Completed frame sets receive flag; interrupt only when enabled.
// - Buffer read returns oldest frame low byte and removes it.
// - Clearing continuous receive clears a latched error.
// - Third frame with two unread buffered sets overrun.
// - Address detect filters nine-bit frames; cleared, all frames enter.
// - Priority bit steers receive interrupt high or low.
// - In sleep the baud generator stops; no frame reception.
// - Wake enable holds receiver idle, watching for wake.
// - Wake only in async mode; wake is any falling line edge.
// - Wake event sets receive flag; buffer read clears it.
// - First rising edge after wake clears wake enable.
// - Unimplemented baud control bit 2 reads zero, ignores writes.
// - Data bits arrive least significant first.
// - Generator runs at sixteen or sixty-four times bit rate.
module asrw_rx
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire asrw_pkg::asrw_req_t bus_i,
   output logic [7:0] rd_data_o,
   // Serial line and power state
   input wire logic rx_line_i,
   input wire logic sleep_i,
   // Receive interrupt requests
   output logic irq_high_o,
   output logic irq_low_o
);

   typedef struct packed {
      logic [7:0] rdata;
      logic irq_hi;
      logic irq_lo;
      logic port_enable;
      logic rx9;
      logic continuous_rx_enable;
      logic address_detect_enable;
      logic sync;
      logic high_speed_baud_select;
      logic wide_divisor_select;
      logic rxpol;
      logic txpol;
      logic wake_enable;
      logic rie;
      logic rip;
      logic [7:0] div_hi;
      logic [7:0] div_lo;
      logic [15:0] bcnt;
      logic [1:0] pre;
      logic [3:0] scnt;
      logic [3:0] bitn;
      asrw_pkg::asrw_fsm_t fsm;
      logic [8:0] sh;
      asrw_pkg::asrw_entry_t buf0;
      asrw_pkg::asrw_entry_t buf1;
      logic [1:0] cnt;
      logic overrun_error_flag;
      logic rx_prev;
      logic wake_seen;
      logic wake_flag;
   } asrw_state_t;

   asrw_state_t s_q;
   asrw_state_t s_d;

   logic rx;
   logic rx_en;
   logic bg_tick;
   logic stick;
   logic frame_done;
   logic discard;
   logic pop;
   logic fall;
   logic rise;
   logic flag_d;
   logic [1:0] n;
   logic [15:0] divisor;
   logic [3:0] nbits;
   asrw_pkg::asrw_entry_t fresh;

   // Line level after optional inversion
   assign rx = rx_line_i ^ s_q.rxpol;
   // Async receive only with port on, sync off, no wake, no sleep
   assign rx_en = s_q.port_enable & ~s_q.sync & s_q.continuous_rx_enable & ~s_q.wake_enable
      & ~sleep_i;
   assign fall = s_q.rx_prev & ~rx;
   assign rise = ~s_q.rx_prev & rx;
   assign divisor = s_q.wide_divisor_select ? {s_q.div_hi, s_q.div_lo}
      : {8'h00, s_q.div_lo};
   assign nbits = s_q.rx9 ? asrw_pkg::BITS_NINE : asrw_pkg::BITS_EIGHT;
   assign pop = bus_i.rd & (bus_i.addr == asrw_pkg::ADDR_RX_BUFFER)
      & (s_q.cnt != 2'h0);

   // Next-state logic for the whole block
   always_comb
   begin
      s_d = s_q;
      bg_tick = 1'b0;
      stick = 1'b0;
      frame_done = 1'b0;
      n = s_q.cnt;
      fresh.framing_error_flag = ~rx;
      fresh.ninth = s_q.rx9 ? s_q.sh[8] : 1'b0;
      fresh.data = s_q.rx9 ? s_q.sh[7:0] : s_q.sh[8:1];
      discard = s_q.rx9 & s_q.address_detect_enable & ~fresh.ninth;
      s_d.rx_prev = rx;

      // Baud generator halts while asleep or receive is off
      if (rx_en)
      begin
         if (s_q.bcnt >= divisor)
         begin
            s_d.bcnt = 16'h0000;
            bg_tick = 1'b1;
         end
         else
         begin
            s_d.bcnt = s_q.bcnt + 16'h0001;
         end
      end
      else
      begin
         s_d.bcnt = 16'h0000;
         s_d.pre = 2'h0;
      end
      // Both selects clear means a x64 clock, divided down to x16
      if (bg_tick)
      begin
         if (s_q.high_speed_baud_select | s_q.wide_divisor_select)
         begin
            stick = 1'b1;
         end
         else
         begin
            s_d.pre = s_q.pre + 2'h1;
            stick = (s_q.pre == asrw_pkg::PRE_X64_LAST);
         end
      end

      // Frame sequencer on x16 sample ticks
      if (!rx_en)
      begin
         s_d.fsm = asrw_pkg::RX_IDLE;
         s_d.scnt = 4'h0;
      end
      else if (stick)
      begin
         s_d.scnt = s_q.scnt + 4'h1;
         unique case (s_q.fsm)
            asrw_pkg::RX_IDLE:
            begin
               s_d.scnt = 4'h0;
               if (!rx)
               begin
                  s_d.fsm = asrw_pkg::RX_START;
               end
            end
            asrw_pkg::RX_START:
            begin
               // A glitch shorter than half a bit is not a start
               if (s_q.scnt == asrw_pkg::SMP_START_MID)
               begin
                  s_d.scnt = 4'h0;
                  s_d.bitn = 4'h0;
                  s_d.fsm = rx ? asrw_pkg::RX_IDLE : asrw_pkg::RX_DATA;
               end
            end
            asrw_pkg::RX_DATA:
            begin
               if (s_q.scnt == asrw_pkg::SMP_LAST)
               begin
                  s_d.sh = {rx, s_q.sh[8:1]};
                  s_d.bitn = s_q.bitn + 4'h1;
                  if (s_q.bitn == nbits - 4'h1)
                  begin
                     s_d.fsm = asrw_pkg::RX_STOP;
                  end
               end
            end
            asrw_pkg::RX_STOP:
            begin
               if (s_q.scnt == asrw_pkg::SMP_LAST)
               begin
                  frame_done = 1'b1;
                  s_d.fsm = asrw_pkg::RX_IDLE;
               end
            end
            default:
            begin
               s_d.fsm = asrw_pkg::RX_IDLE;
            end
         endcase
      end

      // Two-entry receive buffer; the read pop is taken first
      if (pop)
      begin
         s_d.buf0 = s_q.buf1;
         n = s_q.cnt - 2'h1;
      end
      if (frame_done && !discard && !s_q.overrun_error_flag)
      begin
         if (n == asrw_pkg::FIFO_DEPTH)
         begin
            s_d.overrun_error_flag = 1'b1;
         end
         else
         begin
            if (n == 2'h0)
            begin
               s_d.buf0 = fresh;
            end
            else
            begin
               s_d.buf1 = fresh;
            end
            n = n + 2'h1;
         end
      end
      s_d.cnt = n;

      // Wake watch: falling edge raises the flag, rising edge ends it
      if (s_q.wake_enable && !s_q.sync && !s_q.wake_seen && fall)
      begin
         s_d.wake_seen = 1'b1;
      end
      if (s_q.wake_enable && s_q.wake_seen && rise)
      begin
         s_d.wake_enable = 1'b0;
         s_d.wake_seen = 1'b0;
      end
      if (pop || (bus_i.rd && bus_i.addr == asrw_pkg::ADDR_RX_BUFFER))
      begin
         s_d.wake_flag = 1'b0;
      end
      // Setting beats the read clear in the same cycle
      if (s_q.wake_enable && !s_q.sync && !s_q.wake_seen && fall)
      begin
         s_d.wake_flag = 1'b1;
      end

      // Register writes
      if (bus_i.wr)
      begin
         unique case (bus_i.addr)
            asrw_pkg::ADDR_STATUS:
            begin
               s_d.port_enable = bus_i.wdata[asrw_pkg::STS_PORT_EN];
               s_d.rx9 = bus_i.wdata[asrw_pkg::STS_NINE_BIT];
               s_d.continuous_rx_enable = bus_i.wdata[asrw_pkg::STS_CONT_RX];
               s_d.address_detect_enable = bus_i.wdata[asrw_pkg::STS_ADDR_DET];
            end
            asrw_pkg::ADDR_BAUD_CTRL:
            begin
               s_d.rxpol = bus_i.wdata[asrw_pkg::BC_RX_POL];
               s_d.txpol = bus_i.wdata[asrw_pkg::BC_TX_POL];
               s_d.wide_divisor_select = bus_i.wdata[asrw_pkg::BC_WIDE_DIV];
               s_d.wake_enable = bus_i.wdata[asrw_pkg::BC_WAKE];
               s_d.wake_seen = 1'b0;
            end
            asrw_pkg::ADDR_DIV_HIGH: s_d.div_hi = bus_i.wdata;
            asrw_pkg::ADDR_DIV_LOW: s_d.div_lo = bus_i.wdata;
            asrw_pkg::ADDR_IRQ_ENABLES:
               s_d.rie = bus_i.wdata[asrw_pkg::IRQ_RX_BIT];
            asrw_pkg::ADDR_IRQ_PRIO:
               s_d.rip = bus_i.wdata[asrw_pkg::IRQ_RX_BIT];
            asrw_pkg::ADDR_TX_STATUS:
            begin
               s_d.sync = bus_i.wdata[asrw_pkg::TS_SYNC];
               s_d.high_speed_baud_select = bus_i.wdata[asrw_pkg::TS_HIGH_SPEED];
            end
            default:
            begin
            end
         endcase
      end
      // Error stays latched until continuous receive drops
      if (!s_d.continuous_rx_enable)
      begin
         s_d.overrun_error_flag = 1'b0;
      end

      // Register reads, data stand for one cycle
      s_d.rdata = 8'h00;
      if (bus_i.rd)
      begin
         unique case (bus_i.addr)
            asrw_pkg::ADDR_STATUS:
               s_d.rdata = {s_q.port_enable, s_q.rx9, 1'b0, s_q.continuous_rx_enable, s_q.address_detect_enable,
                  s_q.buf0.framing_error_flag, s_q.overrun_error_flag, s_q.buf0.ninth};
            asrw_pkg::ADDR_BAUD_CTRL:
               s_d.rdata = {1'b0, s_q.fsm == asrw_pkg::RX_IDLE, s_q.rxpol,
                  s_q.txpol, s_q.wide_divisor_select, 1'b0, s_q.wake_enable, 1'b0};
            asrw_pkg::ADDR_DIV_HIGH: s_d.rdata = s_q.div_hi;
            asrw_pkg::ADDR_DIV_LOW: s_d.rdata = s_q.div_lo;
            asrw_pkg::ADDR_RX_BUFFER: s_d.rdata = s_q.buf0.data;
            asrw_pkg::ADDR_IRQ_FLAGS:
               s_d.rdata[asrw_pkg::IRQ_RX_BIT] =
                  (s_q.cnt != 2'h0) | s_q.wake_flag;
            asrw_pkg::ADDR_IRQ_ENABLES:
               s_d.rdata[asrw_pkg::IRQ_RX_BIT] = s_q.rie;
            asrw_pkg::ADDR_IRQ_PRIO:
               s_d.rdata[asrw_pkg::IRQ_RX_BIT] = s_q.rip;
            asrw_pkg::ADDR_TX_STATUS:
               s_d.rdata = {3'h0, s_q.sync, 1'b0, s_q.high_speed_baud_select, 2'h0};
            default: s_d.rdata = 8'h00;
         endcase
      end

      // Receive flag is derived from buffer and wake state
      flag_d = (s_d.cnt != 2'h0) | s_d.wake_flag;
      s_d.irq_hi = flag_d & s_d.rie & s_d.rip;
      s_d.irq_lo = flag_d & s_d.rie & ~s_d.rip;
   end

   // State register, synchronous reset
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         s_q <= '0;
         s_q.fsm <= asrw_pkg::RX_IDLE;
         s_q.rx_prev <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign rd_data_o = s_q.rdata;
   assign irq_high_o = s_q.irq_hi;
   assign irq_low_o = s_q.irq_lo;

   // Checks on the receive path
   a_overrun_sets: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      frame_done && !discard && !s_q.overrun_error_flag && s_q.continuous_rx_enable && !pop
      && s_q.cnt == 2'h2 |=> s_q.overrun_error_flag)
      else $error("third frame did not raise overrun");
   a_continuous_rx_enable_clears: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !s_q.continuous_rx_enable |-> !s_q.overrun_error_flag)
      else $error("overrun held with receive disabled");
   a_frame_flags: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      frame_done && !discard && !s_q.overrun_error_flag && s_q.cnt == 2'h0 && s_q.rie
      && !bus_i.wr |-> ##2 (irq_high_o | irq_low_o))
      else $error("accepted frame raised no interrupt");
   a_prio_low: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      $rose(irq_low_o) |-> !s_q.rip && !irq_high_o)
      else $error("low request with high priority set");
   a_wake_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      s_q.wake_enable |-> s_q.fsm == asrw_pkg::RX_IDLE)
      else $error("receiver active during wake watch");
   a_wake_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      s_q.wake_enable && !s_q.sync && !s_q.wake_seen && fall
      |=> s_q.wake_flag ##1 (irq_high_o | irq_low_o | !s_q.rie))
      else $error("wake edge did not set the flag");
   a_wake_ends: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      s_q.wake_enable && s_q.wake_seen && rise && !bus_i.wr |=> !s_q.wake_enable)
      else $error("wake enable not cleared on rising edge");
   a_addr_drop: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      frame_done && discard && !pop |=> $stable(s_q.cnt))
      else $error("address filter let a data frame in");
   a_pad_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      bus_i.rd && bus_i.addr == asrw_pkg::ADDR_BAUD_CTRL |=> !rd_data_o[2])
      else $error("unimplemented baud bit read as one");
   a_no_sleep_rx: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      sleep_i |-> !frame_done && !bg_tick)
      else $error("reception while asleep");

   c_frame: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      frame_done && !discard);
   c_overrun: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      $rose(s_q.overrun_error_flag));
   c_wake: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      $fell(s_q.wake_enable));

endmodule // asrw_rx
